// file: pkg/mfs_map.vh
// Register map, field positions, reset values and timing counts for the fan setup register bank
`ifndef MFS_MAP_VH
`define MFS_MAP_VH
// ----------------------------------------
// Register offsets (register index; byte address is four times this)
// ----------------------------------------
`define MFS_IDX_TACH_MODE 8'hBD
`define MFS_IDX_IN_THRESH 8'hBE
`define MFS_IDX_RAMP 8'hBF
`define MFS_IDX_BOOST_12 8'hC0
`define MFS_IDX_BOOST_34 8'hC1
`define MFS_IDX_FILTER 8'hC2
`define MFS_IDX_FLOOR_12 8'hC3
`define MFS_IDX_FLOOR_34 8'hC4
`define MFS_IDX_ODRAIN 8'hC5
// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define MFS_RST_ZERO 8'h00
`define MFS_RST_BOOST 8'h44
`define MFS_RST_FLOOR 8'h00
`define MFS_MASK_TACH_MODE 8'h3F
`define MFS_MASK_IN_THRESH 8'hF3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define MFS_BIT_HALF_A 4
`define MFS_BIT_HALF_B 5
`define MFS_BIT_FUSE_ONE 3
`define MFS_BIT_FUSE_TWO 7
// ----------------------------------------
// Timing
// ----------------------------------------
`define MFS_CLK_HZ 200000000
`define MFS_STEP_MS 50
`define MFS_STEP_CYCLES ((`MFS_CLK_HZ / 1000) * `MFS_STEP_MS)
`define MFS_SMOOTH_BASE_MS 400
`endif

// file: design/mfs_ramp_timer.v
// Ramp step timer: one-cycle step pulse every code times the step period; step held high while code is zero
`timescale 1ns/1ps
module mfs_ramp_timer #(
   parameter STEP_CYCLES = 10000000,
   parameter CW = 24
)
(
   input wire clock_i,
   input wire reset_n_i,
   input wire active_i,
   input wire [3:0] code_i,
   output reg step_o
);
   reg [CW-1:0] tick_reg;
   reg [3:0] units_reg;
   wire tick_end;
   assign tick_end = (tick_reg == STEP_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});
   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always @(posedge clock_i)
   begin
      if (!reset_n_i || !active_i)
      begin
         tick_reg <= {CW{1'b0}};
         units_reg <= 4'h0;
         step_o <= 1'b0;
      end
      else if (code_i == 4'h0)
      begin
         step_o <= 1'b1;
      end
      else
      begin
         step_o <= 1'b0;
         if (tick_end)
         begin
            tick_reg <= {CW{1'b0}};
            if (units_reg + 4'h1 >= code_i)
            begin
               units_reg <= 4'h0;
               step_o <= 1'b1;
            end
            else
            begin
               units_reg <= units_reg + 4'h1;
            end
         end
         else
         begin
            tick_reg <= tick_reg + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// file: design/mfs_setup_regs.v
// Fan-control setup register bank with ramp, boost, filter and open-drain logic
`timescale 1ns/1ps
`include "mfs_map.vh"
module mfs_setup_regs #(
   parameter STEP_CYCLES = `MFS_STEP_CYCLES,
   parameter SMOOTH_UNIT_CYCLES = 8000
)
(
   input wire clock_i,
   input wire reset_n_i,
   input wire [9:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   input wire regulator_overheat_input_i,
   input wire cpu_overheat_signal_i,
   input wire [31:0] zone_temp_i,
   input wire [31:0] boost_temp_i,
   output reg [3:0] smart_tach_enable_o,
   output reg [1:0] half_degree_o,
   output reg [5:0] low_threshold_o,
   output reg [7:0] regulator_ramp_duty_o,
   output reg [7:0] cpu_hot_ramp_duty_o,
   output reg [3:0] boost_active_o,
   output reg [15:0] raw_temp_o,
   output reg [15:0] filtered_temp_o,
   output reg [15:0] used_temp_o,
   output reg [3:0] floor_duty_code_a_o,
   output reg [3:0] floor_duty_code_b_o,
   output reg [3:0] auto_fan_hyst_a_o,
   output reg [3:0] auto_fan_hyst_b_o,
   output reg [2:0] open_drain_out_o,
   output reg [2:0] open_drain_oe_n_o
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] tach_mode_reg;
   reg [7:0] in_thresh_reg;
   reg [7:0] ramp_reg;
   reg [7:0] boost12_reg;
   reg [7:0] boost34_reg;
   reg [7:0] filter_reg;
   reg [7:0] floor12_reg;
   reg [7:0] floor34_reg;
   reg [7:0] odrain_reg;
   reg ack_reg;
   reg [7:0] rd_next;
   wire [7:0] idx;
   wire wr_go;
   wire rd_go;
   wire [7:0] wdat;
   assign idx = avs_address_i[9:2];
   assign wr_go = avs_write_i && ack_reg && avs_byteenable_i[0];
   assign rd_go = avs_read_i && !ack_reg;
   assign wdat = avs_writedata_i[7:0];
   // ----------------------------------------
   // Bus slave: one wait cycle, then acknowledge
   // ----------------------------------------
   always @*
   begin
      case (idx)
         `MFS_IDX_TACH_MODE: rd_next = tach_mode_reg;
         `MFS_IDX_IN_THRESH: rd_next = in_thresh_reg;
         `MFS_IDX_RAMP: rd_next = ramp_reg;
         `MFS_IDX_BOOST_12: rd_next = boost12_reg;
         `MFS_IDX_BOOST_34: rd_next = boost34_reg;
         `MFS_IDX_FILTER: rd_next = filter_reg;
         `MFS_IDX_FLOOR_12: rd_next = floor12_reg;
         `MFS_IDX_FLOOR_34: rd_next = floor34_reg;
         `MFS_IDX_ODRAIN: rd_next = odrain_reg;
         default: rd_next = 8'h00;
      endcase
   end
   always @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         ack_reg <= 1'b0;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o <= 32'h00000000;
      end
      else
      begin
         ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack_reg);
         if (rd_go)
         begin
            avs_readdata_o <= {24'h000000, rd_next};
         end
      end
   end
   // Writes land on the acknowledge edge
   always @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         tach_mode_reg <= `MFS_RST_ZERO;
         in_thresh_reg <= `MFS_RST_ZERO;
         ramp_reg <= `MFS_RST_ZERO;
         boost12_reg <= `MFS_RST_BOOST;
         boost34_reg <= `MFS_RST_BOOST;
         filter_reg <= `MFS_RST_ZERO;
         floor12_reg <= `MFS_RST_FLOOR;
         floor34_reg <= `MFS_RST_FLOOR;
         odrain_reg <= `MFS_RST_ZERO;
      end
      else if (wr_go)
      begin
         case (idx)
            `MFS_IDX_TACH_MODE: tach_mode_reg <= wdat & `MFS_MASK_TACH_MODE;
            `MFS_IDX_IN_THRESH: in_thresh_reg <= wdat & `MFS_MASK_IN_THRESH;
            `MFS_IDX_RAMP: ramp_reg <= wdat;
            `MFS_IDX_BOOST_12: boost12_reg <= wdat;
            `MFS_IDX_BOOST_34: boost34_reg <= wdat;
            `MFS_IDX_FILTER: filter_reg <= wdat;
            `MFS_IDX_FLOOR_12: floor12_reg <= wdat;
            `MFS_IDX_FLOOR_34: floor34_reg <= wdat;
            `MFS_IDX_ODRAIN: odrain_reg <= wdat;
            default: odrain_reg <= odrain_reg;
         endcase
      end
   end
   // ----------------------------------------
   // Static configuration outputs
   // ----------------------------------------
   always @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         smart_tach_enable_o <= 4'h0;
         half_degree_o <= 2'b00;
         low_threshold_o <= 6'h00;
         floor_duty_code_a_o <= 4'h0;
         floor_duty_code_b_o <= 4'h0;
         auto_fan_hyst_a_o <= 4'h0;
         auto_fan_hyst_b_o <= 4'h0;
         open_drain_out_o <= 3'h0;
         open_drain_oe_n_o <= 3'h7;
      end
      else
      begin
         smart_tach_enable_o <= tach_mode_reg[3:0];
         half_degree_o <= {tach_mode_reg[`MFS_BIT_HALF_B], tach_mode_reg[`MFS_BIT_HALF_A]};
         low_threshold_o <= {in_thresh_reg[7:4], in_thresh_reg[1:0]};
         floor_duty_code_a_o <= floor12_reg[7:4];
         floor_duty_code_b_o <= floor34_reg[7:4];
         auto_fan_hyst_a_o <= floor12_reg[3:0];
         auto_fan_hyst_b_o <= floor34_reg[3:0];
         // Open drain: drive low only, enable low while driving
         open_drain_out_o <= 3'h0;
         open_drain_oe_n_o <= ~odrain_reg[2:0];
      end
   end
   // ----------------------------------------
   // Ramps: step up toward full while the overheat input holds (jump straight to full at code zero), down otherwise
   // ----------------------------------------
   wire reg_step;
   wire cpu_step;
   mfs_ramp_timer #(.STEP_CYCLES(STEP_CYCLES), .CW(32)) u_reg_timer (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .active_i(regulator_overheat_input_i || regulator_ramp_duty_o != 8'h00),
      .code_i(ramp_reg[3:0]),
      .step_o(reg_step)
   );
   mfs_ramp_timer #(.STEP_CYCLES(STEP_CYCLES), .CW(32)) u_cpu_timer (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .active_i(cpu_overheat_signal_i || cpu_hot_ramp_duty_o != 8'h00),
      .code_i(ramp_reg[7:4]),
      .step_o(cpu_step)
   );
   always @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         regulator_ramp_duty_o <= 8'h00;
         cpu_hot_ramp_duty_o <= 8'h00;
      end
      else
      begin
         if (regulator_overheat_input_i && ramp_reg[3:0] == 4'h0)
            regulator_ramp_duty_o <= 8'hFF;
         else if (reg_step && regulator_overheat_input_i && regulator_ramp_duty_o != 8'hFF)
            regulator_ramp_duty_o <= regulator_ramp_duty_o + 8'h01;
         else if (reg_step && !regulator_overheat_input_i && regulator_ramp_duty_o != 8'h00)
            regulator_ramp_duty_o <= regulator_ramp_duty_o - 8'h01;
         if (cpu_overheat_signal_i && ramp_reg[7:4] == 4'h0)
            cpu_hot_ramp_duty_o <= 8'hFF;
         else if (cpu_step && cpu_overheat_signal_i && cpu_hot_ramp_duty_o != 8'hFF)
            cpu_hot_ramp_duty_o <= cpu_hot_ramp_duty_o + 8'h01;
         else if (cpu_step && !cpu_overheat_signal_i && cpu_hot_ramp_duty_o != 8'h00)
            cpu_hot_ramp_duty_o <= cpu_hot_ramp_duty_o - 8'h01;
      end
   end
   // ----------------------------------------
   // Smoothing filters, zones one and two
   // ----------------------------------------
   // Span per code, in smoothing units; a shift filter approximates the averaging span
   function [2:0] span_shift;
      input [2:0] code;
      begin
         span_shift = 3'h7 - code;
      end
   endfunction
   reg [31:0] sm_cnt_reg;
   wire [31:0] filt_acc;
   wire sm_tick;
   assign sm_tick = (sm_cnt_reg == SMOOTH_UNIT_CYCLES - 1);
   always @(posedge clock_i)
   begin
      if (!reset_n_i || sm_tick)
         sm_cnt_reg <= 32'h00000000;
      else
         sm_cnt_reg <= sm_cnt_reg + 32'h00000001;
   end
   genvar z;
   generate
      for (z = 0; z < 2; z = z + 1)
      begin : g_filt
         wire [2:0] code;
         wire [7:0] raw;
         wire [15:0] acc;
         reg [15:0] acc_reg;
         wire [15:0] delta;
         assign code = z ? filter_reg[6:4] : filter_reg[2:0];
         assign raw = zone_temp_i[z*8 +: 8];
         assign acc = acc_reg;
         assign filt_acc[z*16 +: 16] = acc_reg;
         assign delta = ({raw, 8'h00} >= acc) ? (({raw, 8'h00} - acc) >> span_shift(code))
                                              : ((acc - {raw, 8'h00}) >> span_shift(code));
         always @(posedge clock_i)
         begin
            if (!reset_n_i)
               acc_reg <= 16'h0000;
            else if (sm_tick)
               acc_reg <= ({raw, 8'h00} >= acc) ? acc + delta : acc - delta;
         end
      end
   endgenerate
   always @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         raw_temp_o <= 16'h0000;
         filtered_temp_o <= 16'h0000;
         used_temp_o <= 16'h0000;
      end
      else
      begin
         raw_temp_o <= zone_temp_i[15:0];
         filtered_temp_o <= {filt_acc[31:24], filt_acc[15:8]};
         used_temp_o[7:0] <= filter_reg[`MFS_BIT_FUSE_ONE] ? filt_acc[15:8] : zone_temp_i[7:0];
         used_temp_o[15:8] <= filter_reg[`MFS_BIT_FUSE_TWO] ? filt_acc[31:24] : zone_temp_i[15:8];
      end
   end
   // ----------------------------------------
   // Fan boost with hysteresis, per zone
   // ----------------------------------------
   wire [15:0] boost_hyst;
   wire [31:0] boost_src;
   wire [3:0] boost_set;
   wire [3:0] boost_clr;
   assign boost_hyst = {boost34_reg, boost12_reg};
   // Zones one and two follow the filter-use selection, three and four stay raw
   assign boost_src = {zone_temp_i[31:16], used_temp_o};
   generate
      for (z = 0; z < 4; z = z + 1)
      begin : g_boost
         wire [7:0] t;
         wire [8:0] release_lvl;
         assign t = boost_src[z*8 +: 8];
         assign release_lvl = {1'b0, boost_temp_i[z*8 +: 8]} - {5'h00, boost_hyst[z*4 +: 4]};
         assign boost_set[z] = (t > boost_temp_i[z*8 +: 8]);
         // A boost level below the hysteresis wraps; such a zone is never released
         assign boost_clr[z] = !release_lvl[8] && ({1'b0, t} < release_lvl);
      end
   endgenerate
   // Set wins over release should both hold in one cycle
   always @(posedge clock_i)
   begin
      if (!reset_n_i)
         boost_active_o <= 4'h0;
      else
         boost_active_o <= boost_set | (boost_active_o & ~boost_clr);
   end
endmodule

// file: tb/mfs_setup_regs_monitor.sv
// Concurrent checks on the fan setup register bank ports
`timescale 1ns/1ps
`include "mfs_map.vh"
module mfs_setup_regs_monitor (
   input wire clock_i,
   input wire reset_n_i,
   input wire [9:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire [31:0] zone_temp_i,
   input wire [31:0] boost_temp_i,
   input wire [3:0] smart_tach_enable_o,
   input wire [1:0] half_degree_o,
   input wire [5:0] low_threshold_o,
   input wire [3:0] boost_active_o,
   input wire [3:0] floor_duty_code_a_o,
   input wire [3:0] auto_fan_hyst_a_o,
   input wire [2:0] open_drain_out_o,
   input wire [2:0] open_drain_oe_n_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Last accepted write byte; next write lands no sooner than two edges later
   reg [7:0] wd_reg = 8'h00;
   always @(posedge clock_i)
   begin
      if (avs_write_i && !avs_waitrequest_o)
         wd_reg <= avs_writedata_i[7:0];
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_wr(idx);
      avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i[9:2] == idx;
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_TACH_EN: assert property (s_wr(`MFS_IDX_TACH_MODE) |-> ##2 smart_tach_enable_o == wd_reg[3:0])
      else $error("smart tach enables do not follow write");
   AST_HALF_DEG: assert property (s_wr(`MFS_IDX_TACH_MODE) |-> ##2 half_degree_o == wd_reg[5:4])
      else $error("resolution bits do not follow write");
   AST_LOW_THR: assert property (s_wr(`MFS_IDX_IN_THRESH) |-> ##2 low_threshold_o == {wd_reg[7:4], wd_reg[1:0]})
      else $error("threshold selects do not follow write");
   AST_RSV_READ: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[9:2] == `MFS_IDX_IN_THRESH
      |-> avs_readdata_o[31:8] == 24'h0 && avs_readdata_o[3:2] == 2'h0)
      else $error("reserved threshold bits read nonzero");
   AST_FLOOR: assert property (s_wr(`MFS_IDX_FLOOR_12) |-> ##2 floor_duty_code_a_o == wd_reg[7:4]
      && auto_fan_hyst_a_o == wd_reg[3:0])
      else $error("floor or hysteresis fields do not follow write");
   AST_OD_PULL: assert property (s_wr(`MFS_IDX_ODRAIN) |-> ##2 open_drain_oe_n_o == ~wd_reg[2:0])
      else $error("open drain enables do not follow write");
   AST_OD_NEVER_HIGH: assert property (open_drain_out_o == 3'h0)
      else $error("open drain pin driven high");
   AST_BOOST_SET: assert property ($rose(boost_active_o[2]) |-> $past(zone_temp_i[23:16] > boost_temp_i[23:16])
      || $past(zone_temp_i[23:16] > boost_temp_i[23:16], 2))
      else $error("boost raised without exceeding boost temperature");
   AST_BOOST_HOLD: assert property (boost_active_o[2] && zone_temp_i[23:16] >= boost_temp_i[23:16]
      |=> boost_active_o[2])
      else $error("boost dropped while still at boost temperature");
   AST_WAIT_ONE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
endmodule
bind mfs_setup_regs mfs_setup_regs_monitor u_mon (.clock_i(clock_i), .reset_n_i(reset_n_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .zone_temp_i(zone_temp_i), .boost_temp_i(boost_temp_i),
   .smart_tach_enable_o(smart_tach_enable_o), .half_degree_o(half_degree_o), .low_threshold_o(low_threshold_o),
   .boost_active_o(boost_active_o), .floor_duty_code_a_o(floor_duty_code_a_o),
   .auto_fan_hyst_a_o(auto_fan_hyst_a_o), .open_drain_out_o(open_drain_out_o),
   .open_drain_oe_n_o(open_drain_oe_n_o));

// file: tb/test_mfs_setup_regs.sv
// Self-checking testbench for the fan setup register bank
`timescale 1ns/1ps
module test_mfs_setup_regs;
   reg clock_i = 1'b0;
   reg reset_n_i = 1'b0;
   reg [9:0] adr = 10'h000;
   reg rd_r = 1'b0;
   reg wr_r = 1'b0;
   reg [31:0] wd = 32'h0;
   reg [3:0] be = 4'h0;
   reg rhot = 1'b0;
   reg chot = 1'b0;
   reg [31:0] zt = 32'h0;
   reg [31:0] bt = 32'hFFFFFFFF;
   wire [31:0] rdata;
   wire wait_o;
   wire [3:0] ste, bst, fa, fb, ha, hb;
   wire [1:0] hd;
   wire [5:0] lt;
   wire [7:0] rdut, cdut;
   wire [15:0] rawt, filt, used;
   wire [2:0] odo, odn;
   integer err_count = 0;
   integer checked = 0;
   integer i;
   integer n;
   reg [31:0] q;
   always #2.5 clock_i = ~clock_i;
   // Short step and smoothing units keep ramp and filter runs brief
   mfs_setup_regs #(.STEP_CYCLES(4), .SMOOTH_UNIT_CYCLES(4)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .avs_address_i(adr), .avs_read_i(rd_r), .avs_write_i(wr_r), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .regulator_overheat_input_i(rhot),
      .cpu_overheat_signal_i(chot), .zone_temp_i(zt), .boost_temp_i(bt), .smart_tach_enable_o(ste),
      .half_degree_o(hd), .low_threshold_o(lt), .regulator_ramp_duty_o(rdut), .cpu_hot_ramp_duty_o(cdut),
      .boost_active_o(bst), .raw_temp_o(rawt), .filtered_temp_o(filt), .used_temp_o(used),
      .floor_duty_code_a_o(fa), .floor_duty_code_b_o(fb), .auto_fan_hyst_a_o(ha), .auto_fan_hyst_b_o(hb),
      .open_drain_out_o(odo), .open_drain_oe_n_o(odn));
   // ----------------------------------------
   // Common tasks
   // ----------------------------------------
   task results;
   begin
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      checked = checked + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task ack;
   begin
      n = 0;
      @(posedge clock_i);
      while (wait_o !== 1'b0)
      begin
         n = n + 1;
         if (n > 50)
         begin
            err_count = err_count + 1;
            results;
         end
         @(posedge clock_i);
      end
   end
   endtask
   task wr(input [7:0] idx, input [7:0] d, input [3:0] b);
   begin
      @(posedge clock_i);
      adr <= {idx, 2'b00};
      wd <= {24'h0, d};
      be <= b;
      wr_r <= 1'b1;
      ack;
      wr_r <= 1'b0;
   end
   endtask
   task rd(input [7:0] idx);
   begin
      @(posedge clock_i);
      adr <= {idx, 2'b00};
      rd_r <= 1'b1;
      ack;
      q = rdata;
      rd_r <= 1'b0;
   end
   endtask
   // Cycles until the regulator ramp duty moves, bounded
   task wchg;
      reg [7:0] v;
   begin
      v = rdut;
      n = 0;
      while (rdut === v)
      begin
         @(posedge clock_i);
         n = n + 1;
         if (n > 100)
         begin
            err_count = err_count + 1;
            results;
         end
      end
   end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
   begin
      for (i = 0; i < 9; i = i + 1)
      begin
         rd(8'hBD + i);
         chk(q, (i == 3 || i == 4) ? 32'h44 : 32'h0);
      end
      for (i = 0; i < 9; i = i + 1)
      begin
         wr(8'hBD + i, 8'hFF, 4'hF);
         rd(8'hBD + i);
         chk(q, i == 0 ? 32'h3F : (i == 1 ? 32'hF3 : 32'hFF));
      end
      wr(8'hC6, 8'hFF, 4'hF);
      rd(8'hC6);
      chk(q, 32'h0);
      wr(8'hBF, 8'h55, 4'h0);
      rd(8'hBF);
      chk(q, 32'hFF);
      for (i = 0; i < 9; i = i + 1)
         wr(8'hBD + i, (i == 3 || i == 4) ? 8'h44 : 8'h00, 4'hF);
   end
   endtask
   // No limit or error-status writes are made against this bank
   task t_cfg;
   begin
      // No fast PWM or binding register sits here, so enables are set freely
      wr(8'hBD, 8'h2A, 4'hF);
      wr(8'hBE, 8'h96, 4'hF);
      wr(8'hC3, 8'h7B, 4'hF);
      wr(8'hC4, 8'hD2, 4'hF);
      wr(8'hC5, 8'h05, 4'hF);
      repeat (3) @(posedge clock_i);
      chk(ste, 4'hA);
      chk(hd, 2'h2);
      chk(lt, 6'h26);
      chk({fa, ha, fb, hb}, 16'h7BD2);
      chk({odo, odn}, 6'h02);
   end
   endtask
   task t_ramp;
   begin
      wr(8'hBF, 8'h03, 4'hF);
      @(posedge clock_i);
      rhot <= 1'b1;
      chot <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk(cdut, 8'hFF);
      chk(rdut < 8'h04, 1'b1);
      wchg;
      wchg;
      chk(n, 12);
      q = {24'h0, rdut};
      rhot <= 1'b0;
      chot <= 1'b0;
      wchg;
      chk(rdut + 8'h01, q);
      wr(8'hBF, 8'h30, 4'hF);
      rhot <= 1'b1;
      repeat (3) @(posedge clock_i);
      chk(rdut, 8'hFF);
      rhot <= 1'b0;
   end
   endtask
   task t_boost;
   begin
      bt <= 32'hFF32FFFF;
      zt <= 32'h00330000;
      repeat (4) @(posedge clock_i);
      chk(bst, 4'h4);
      zt <= 32'h002E0000;
      repeat (4) @(posedge clock_i);
      chk(bst, 4'h4);
      zt <= 32'h002D0000;
      repeat (4) @(posedge clock_i);
      chk(bst, 4'h0);
   end
   endtask
   task t_filter;
   begin
      wr(8'hC2, 8'h08, 4'hF);
      zt <= 32'h002D3050;
      repeat (10) @(posedge clock_i);
      chk(rawt, 16'h3050);
      chk(used[15:8], 8'h30);
      chk(used[7:0] < 8'h50 && filt[7:0] < 8'h50, 1'b1);
      wr(8'hC2, 8'h0F, 4'hF);
      repeat (60) @(posedge clock_i);
      chk({filt[7:0], used[7:0]}, 16'h5050);
      wr(8'hC2, 8'h00, 4'hF);
   end
   endtask
   initial
   begin
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      t_regs;
      t_cfg;
      t_ramp;
      t_boost;
      t_filter;
      results;
   end
endmodule
